// *** adc_sample_fifo.sv ***
// Purpose: Dual-clock sample FIFO between the converter clock and the link clock
// Assumes: DEPTH is a power of two and at least 4
// Notes:   Gray pointers cross through two flip-flops; full and empty are conservative
`timescale 1ns/10ps
`default_nettype none
module adc_sample_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input  wire logic             wr_clk,   // Write clock
  input  wire logic             wr_rst_n, // Async reset, write side
  input  wire logic             wr_valid, // Write request
  output logic                  wr_ready, // Not full
  input  wire logic [WIDTH-1:0] wr_data,  // Write word
  input  wire logic             rd_clk,   // Read clock
  input  wire logic             rd_rst_n, // Async reset, read side
  output logic                  rd_valid, // Not empty
  input  wire logic             rd_ready, // Read accept
  output logic [WIDTH-1:0]      rd_data   // Head word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] meta;
    logic [AW:0] sync;
  } ptr_s;

  ptr_s w_r, w_nxt, r_r, r_nxt;
  logic [WIDTH-1:0] mem [DEPTH];

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  assign wr_ready = (w_r.gray != {~w_r.sync[AW:AW-1], w_r.sync[AW-2:0]});
  assign rd_valid = (r_r.gray != r_r.sync);
  assign rd_data  = mem[r_r.bin[AW-1:0]];

  always_comb begin
    w_nxt      = w_r;
    w_nxt.meta = r_r.gray;
    w_nxt.sync = w_r.meta;
    if (wr_valid && wr_ready) begin
      w_nxt.bin  = w_r.bin + 1'b1;
      w_nxt.gray = bin2gray(w_r.bin + 1'b1);
    end
    r_nxt      = r_r;
    r_nxt.meta = w_r.gray;
    r_nxt.sync = r_r.meta;
    if (rd_valid && rd_ready) begin
      r_nxt.bin  = r_r.bin + 1'b1;
      r_nxt.gray = bin2gray(r_r.bin + 1'b1);
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      w_r <= '0;
    end else begin
      w_r <= w_nxt;
    end
  end

  always_ff @(posedge wr_clk) begin
    if (wr_valid && wr_ready) begin
      mem[w_r.bin[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

endmodule
`default_nettype wire

// *** adc_sync_alignment.sv ***
// Purpose: Alignment reset, sample strobes, test patterns and control register of a quad converter
// Assumes: spi_sclk at most ref_clk/8; align_reset_in retimed by the driver on the falling clock edge
// Notes:   Samples leave through an 8-word FIFO into the link_clk domain
`timescale 1ns/10ps
`default_nettype none
module adc_sync_alignment
  import adc_sync_pkg::*;
#(
  parameter int CH    = CHANNELS,
  parameter int SBITS = SAMPLE_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                ref_clk,        // Converter clock
  input  wire logic                arst_n,         // Async reset, active low
  input  wire logic                link_clk,       // Receiver link clock
  input  wire logic                align_reset_in, // Alignment reset pin, active high
  input  wire logic                spi_sclk,       // Serial register clock
  input  wire logic                spi_cs_n,       // Serial chip select, active low
  input  wire logic                spi_mosi,       // Serial data in
  output logic                     spi_miso_o,     // Serial data out
  output logic                     spi_miso_oe_n,  // Serial out enable, active low
  input  wire logic [CH*SBITS-1:0] sample_in,      // Converter core samples
  output logic [CH-1:0]            data_ready,     // Per-channel sample strobes
  output logic [CH*SBITS-1:0]      link_data,      // Sample word to receiver
  output logic                     link_valid,     // link_data holds a word
  input  wire logic                link_ready      // Receiver accepts word
);
  localparam int W = CH * SBITS;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_HOLD = 3'b010,
    ST_WAIT = 3'b100
  } phase_e;

  typedef struct packed {
    logic             sy_meta;
    logic             sy_sync;
    logic             sy_prev;
    logic             sclk_meta;
    logic             sclk_sync;
    logic             sclk_prev;
    logic             cs_meta;
    logic             cs_sync;
    logic             mosi_meta;
    logic             mosi_sync;
    logic [22:0]      spi_shift;
    logic [4:0]       spi_cnt;
    logic [15:0]      spi_rd;
    logic             miso;
    logic [15:0]      control_config;
    phase_e           phase;
    logic [5:0]       rel_cnt;
    logic             strobe;
    logic [SBITS-1:0] ramp;
    logic [3:0]       flash_cnt;
  } core_s;

  typedef struct packed {
    logic [W-1:0] data;
    logic         valid;
  } link_s;

  localparam core_s CORE_RST = '{
    cs_meta:        1'b1,
    cs_sync:        1'b1,
    control_config: CONTROL_CONFIG_RST,
    phase:          ST_RUN,
    default:        '0
  };

  core_s        s_r, s_nxt;
  link_s        l_r, l_nxt;
  logic         rise_ev, fall_ev, sclk_rise, sclk_fall;
  logic         rm, band, fire;
  test_mode_e   tmode;
  logic [3:0]   zeros;
  logic [5:0]   rel_load;
  logic [15:0]  status;
  logic         wr_valid, wr_ready, rd_valid, rd_ready;
  logic [W-1:0] wr_data, rd_data;
  logic [6:0]   wr_addr;

  function automatic logic [15:0] reg_read(input logic [6:0] addr, input logic [15:0] cfg,
                                           input logic [15:0] stat);
    if (addr == ADDR_CONTROL_CONFIG) begin
      return cfg;
    end else if (addr == ADDR_STATUS) begin
      return stat;
    end
    return 16'h0000;
  endfunction

  // Edge detectors read only the second and third stages of the alignment and sclk synchronisers
  assign rise_ev   = s_r.sy_sync & ~s_r.sy_prev;
  assign fall_ev   = ~s_r.sy_sync & s_r.sy_prev;
  assign sclk_rise = s_r.sclk_sync & ~s_r.sclk_prev;
  assign sclk_fall = ~s_r.sclk_sync & s_r.sclk_prev;

  assign rm       = s_r.control_config[RM_BIT];
  assign band     = s_r.control_config[BAND_BIT];
  assign tmode    = test_mode_e'(s_r.control_config[TEST_LSB +: 2]);
  assign zeros    = flash_zeros(s_r.control_config[FLASH_LSB +: 2]);
  assign rel_load = RELEASE_LOAD + {2'h0, s_r.control_config[DLY_LSB +: 4]} + {5'h00, band};
  assign status   = {11'h000, wr_ready, s_r.strobe, s_r.phase};
  assign wr_addr  = s_r.spi_shift[21:15];

  assign wr_valid = (s_r.phase == ST_RUN);
  assign fire     = wr_valid & wr_ready;

  always_comb begin
    unique case (tmode)
      TEST_RAMP:  wr_data = {CH{s_r.ramp}};
      TEST_FLASH: wr_data = {CH{(s_r.flash_cnt == 4'h0) ? SAMPLE_ONES : 10'h000}};
      default:    wr_data = sample_in;
    endcase
  end

  always_comb begin
    s_nxt           = s_r;
    s_nxt.sy_meta   = align_reset_in;
    s_nxt.sy_sync   = s_r.sy_meta;
    s_nxt.sy_prev   = s_r.sy_sync;
    s_nxt.sclk_meta = spi_sclk;
    s_nxt.sclk_sync = s_r.sclk_meta;
    s_nxt.sclk_prev = s_r.sclk_sync;
    s_nxt.cs_meta   = spi_cs_n;
    s_nxt.cs_sync   = s_r.cs_meta;
    s_nxt.mosi_meta = spi_mosi;
    s_nxt.mosi_sync = s_r.mosi_meta;

    // Serial register port, mode 0: sample on rising, shift out on falling
    if (s_r.cs_sync) begin
      s_nxt.spi_cnt = 5'h00;
    end else begin
      if (sclk_rise && s_r.spi_cnt <= SPI_FRAME_LAST) begin
        s_nxt.spi_shift = {s_r.spi_shift[21:0], s_r.mosi_sync};
        s_nxt.spi_cnt   = s_r.spi_cnt + 5'h01;
        if (s_r.spi_cnt == SPI_ADDR_BITS - 5'h01) begin
          s_nxt.spi_rd = reg_read({s_r.spi_shift[5:0], s_r.mosi_sync}, s_r.control_config, status);
        end
        if (s_r.spi_cnt == SPI_FRAME_LAST && !s_r.spi_shift[22] && wr_addr == ADDR_CONTROL_CONFIG) begin
          s_nxt.control_config = {s_r.spi_shift[14:0], s_r.mosi_sync};
        end
      end
      if (sclk_fall && s_r.spi_cnt >= SPI_ADDR_BITS) begin
        s_nxt.miso   = s_r.spi_rd[15];
        s_nxt.spi_rd = {s_r.spi_rd[14:0], 1'b0};
      end
    end

    // Alignment sequencing; every reset path clears the pattern counters
    unique case (s_r.phase)
      ST_RUN: begin
        if (fall_ev && rm) begin
          s_nxt.phase     = ST_WAIT;
          s_nxt.strobe    = 1'b0;
          s_nxt.ramp      = '0;
          s_nxt.flash_cnt = 4'h0;
          s_nxt.rel_cnt   = rel_load;
        end else if (rise_ev && !rm) begin
          s_nxt.phase     = ST_HOLD;
          s_nxt.strobe    = 1'b0;
          s_nxt.ramp      = '0;
          s_nxt.flash_cnt = 4'h0;
        end else if (fire) begin
          s_nxt.strobe    = ~s_r.strobe;
          s_nxt.ramp      = s_r.ramp + 1'b1;
          s_nxt.flash_cnt = (s_r.flash_cnt >= zeros) ? 4'h0 : s_r.flash_cnt + 4'h1;
        end
      end
      ST_HOLD: begin
        s_nxt.strobe    = 1'b0;
        s_nxt.ramp      = '0;
        s_nxt.flash_cnt = 4'h0;
        if (fall_ev || rm) begin
          s_nxt.phase   = ST_WAIT;
          s_nxt.rel_cnt = rel_load;
        end
      end
      ST_WAIT: begin
        // A new pulse restarts the sequence cleanly
        if (rise_ev && !rm) begin
          s_nxt.phase = ST_HOLD;
        end else if (fall_ev && rm) begin
          s_nxt.rel_cnt = rel_load;
        end else if (s_r.rel_cnt == 6'h00) begin
          s_nxt.phase = ST_RUN;
        end else begin
          s_nxt.rel_cnt = s_r.rel_cnt - 6'h01;
        end
      end
      default: begin
        s_nxt.phase  = ST_HOLD;
        s_nxt.strobe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= CORE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Back-pressure from the FIFO stalls strobes and patterns, so no sample is dropped
  adc_sample_fifo #(
    .WIDTH (W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .wr_clk   (ref_clk),
    .wr_rst_n (arst_n),
    .wr_valid (wr_valid),
    .wr_ready (wr_ready),
    .wr_data  (wr_data),
    .rd_clk   (link_clk),
    .rd_rst_n (arst_n),
    .rd_valid (rd_valid),
    .rd_ready (rd_ready),
    .rd_data  (rd_data)
  );

  assign rd_ready = ~l_r.valid | link_ready;

  always_comb begin
    l_nxt = l_r;
    if (rd_valid && rd_ready) begin
      l_nxt.data  = rd_data;
      l_nxt.valid = 1'b1;
    end else if (link_ready) begin
      l_nxt.valid = 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign data_ready    = {CH{s_r.strobe}};
  assign spi_miso_o    = s_r.miso;
  assign spi_miso_oe_n = s_r.cs_sync;
  assign link_data     = l_r.data;
  assign link_valid    = l_r.valid;

  sequence s_plain_fall;
    fall_ev && s_r.phase == ST_HOLD && s_r.control_config[DLY_LSB +: 4] == 4'h0;
  endsequence

  sequence s_quiet4;
    (!rise_ev)[*4];
  endsequence

  chk_hold_strobe_low: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_r.phase == ST_HOLD |-> data_ready == '0)
    else $error("strobes not low while held in alignment reset");

  chk_rise_enters_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rise_ev && !rm && s_r.phase == ST_RUN) |=> (s_r.phase == ST_HOLD && s_r.strobe == 1'b0))
    else $error("rising alignment edge did not stop strobes");

  chk_release_fixed: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_plain_fall ##0 !band ##1 s_quiet4) |=> s_r.phase == ST_RUN)
    else $error("release delay not equal to fixed count");

  chk_band_extra_cycle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_plain_fall ##0 band ##1 s_quiet4) |=> s_r.phase == ST_WAIT ##1 s_r.phase == ST_RUN)
    else $error("slow band release not one cycle longer");

  chk_rm_keeps_toggle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rm && s_r.sy_sync && s_r.phase == ST_RUN && fire && !fall_ev) |=> s_r.strobe != $past(s_r.strobe))
    else $error("strobe stopped while alignment input high in release mode");

  chk_rm_fall_restarts: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rm && fall_ev && s_r.phase == ST_RUN) |=> (s_r.phase == ST_WAIT && s_r.strobe == 1'b0))
    else $error("falling edge did not restart timing in release mode");

  chk_wait_counters_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_r.phase == ST_WAIT |-> (s_r.ramp == '0 && s_r.flash_cnt == 4'h0))
    else $error("pattern counters not cleared by alignment reset");

  chk_ramp_step: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (fire && !rise_ev && !fall_ev) |=> s_r.ramp == $past(s_r.ramp) + 1'b1)
    else $error("ramp did not advance by one code");

  chk_flash_wrap: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (fire && !rise_ev && !fall_ev && s_r.flash_cnt == zeros) |=> s_r.flash_cnt == 4'h0)
    else $error("flash zero run has wrong length");

  chk_flash_ones: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (tmode == TEST_FLASH && wr_valid) |-> (wr_data[SBITS-1:0] == SAMPLE_ONES) == (s_r.flash_cnt == 4'h0))
    else $error("flash sample value wrong");

  chk_link_hold: assert property (@(posedge link_clk) disable iff (!arst_n)
    (link_valid && !link_ready) |=> (link_valid && $stable(link_data)))
    else $error("link word changed before it was accepted");

  // Release countdown, hold and back-pressure; pin edges are excluded except in the hold checks, which drop only falls or none
  sequence s_wait_done;
    s_r.phase == ST_WAIT && s_r.rel_cnt == 6'h00 && !rise_ev && !fall_ev;
  endsequence

  chk_wait_countdown: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_r.phase == ST_WAIT && s_r.rel_cnt != 6'h00 && !rise_ev && !fall_ev)
      |=> (s_r.phase == ST_WAIT && s_r.rel_cnt == $past(s_r.rel_cnt) - 6'h01))
    else $error("release countdown did not step by one");

  chk_wait_ends_run: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_wait_done |=> s_r.phase == ST_RUN)
    else $error("release wait did not end in run");

  chk_first_strobe: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_wait_done ##1 (fire && !rise_ev && !fall_ev)) |=> data_ready == {CH{1'b1}})
    else $error("strobes did not resume after release");

  chk_hold_stays: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_r.phase == ST_HOLD && !fall_ev && !rm) |=> s_r.phase == ST_HOLD)
    else $error("strobes released while alignment input still high");

  chk_hold_clears: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_r.phase == ST_HOLD |-> (s_r.ramp == '0 && s_r.flash_cnt == 4'h0))
    else $error("pattern counters running during alignment reset");

  chk_stall_freeze: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_r.phase == ST_RUN && !wr_ready && !rise_ev && !fall_ev) |=> ($stable(s_r.strobe) && $stable(s_r.ramp)))
    else $error("strobe or ramp moved while the sample FIFO was full");

endmodule
`default_nettype wire

// *** adc_sync_pkg.sv ***
// Purpose: Shared constants for the converter alignment block and its sample FIFO
// Assumes: 40 MHz ref_clk; register port is a 24-bit serial frame (rw, 7-bit address, 16-bit data)
// Notes:   Field positions refer to control_config unless stated otherwise
package adc_sync_pkg;

  localparam int CHANNELS    = 4;
  localparam int SAMPLE_BITS = 10;
  localparam int FIFO_DEPTH  = 8;

  // Register addresses
  localparam logic [6:0] ADDR_CONTROL_CONFIG = 7'h01;
  localparam logic [6:0] ADDR_STATUS         = 7'h02;

  // Reset values
  localparam logic [15:0] CONTROL_CONFIG_RST = 16'h0000;

  // control_config fields
  localparam int TEST_LSB  = 0;   // 2 bits, test_mode_e
  localparam int FLASH_LSB = 2;   // 2 bits, zero-run select
  localparam int DLY_LSB   = 4;   // 4 bits, extra release delay y
  localparam int RM_BIT    = 10;  // falling_edge_release_mode
  localparam int BAND_BIT  = 11;  // clock between 1.1 and 1.2 GHz

  typedef enum logic [1:0] {
    TEST_NORMAL = 2'h0,
    TEST_RAMP   = 2'h1,
    TEST_FLASH  = 2'h2
  } test_mode_e;

  // Zero-run lengths of the flashing pattern
  localparam logic [3:0] FLASH_ZEROS_A = 4'ha;
  localparam logic [3:0] FLASH_ZEROS_B = 4'hb;
  localparam logic [3:0] FLASH_ZEROS_C = 4'hf;

  // Fixed release delay in ref_clk cycles, loaded as count minus one
  localparam logic [5:0] RELEASE_CYC  = 6'h04;
  localparam logic [5:0] RELEASE_LOAD = RELEASE_CYC - 6'h01;

  localparam logic [4:0] SPI_ADDR_BITS  = 5'h08;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h17;
  localparam logic [9:0] SAMPLE_ONES    = 10'h3ff;

  function automatic logic [3:0] flash_zeros(input logic [1:0] sel);
    unique case (sel)
      2'h0:    return FLASH_ZEROS_A;
      2'h1:    return FLASH_ZEROS_B;
      default: return FLASH_ZEROS_C;
    endcase
  endfunction

endpackage

// *** link_receiver.sv ***
// Purpose: Receiver model that drains the sample link and drives the alignment pin
// Assumes: Link runs free; the pin request comes from the bench in the ref_clk domain
// Notes:   Keeps the first 32 words after clear; counts ramp wraps as a local trigger
`timescale 1ns/10ps
`default_nettype none
module link_receiver (
  input  wire logic         ref_clk,    // Converter clock
  input  wire logic         link_clk,   // Link clock
  input  wire logic         sync_req,   // Pin request
  input  wire logic         stall,      // Hold off words
  input  wire logic         clear,      // Restart capture
  input  wire logic         link_valid, // Word offered
  input  wire logic [39:0]  link_data,  // Offered word
  output logic              link_ready, // Word accepted
  output logic              align_pin,  // Alignment reset pin
  output logic [31:0][39:0] cap,        // Captured words
  output int                rx_count,   // Words taken
  output int                wrap_count  // Ramp wraps seen
);
  // No initial values: clear starts high and the block is in reset before the first edges
  logic [9:0] prev;
  // Falling-edge retime gives the pin half a cycle of setup and hold
  always @(negedge ref_clk) align_pin <= sync_req;
  always @(posedge link_clk) begin
    link_ready <= ~stall;
    if (clear) begin
      rx_count <= 0;
      wrap_count <= 0;
      prev <= 10'h000;
    end else if (link_valid && link_ready) begin
      if (rx_count < 32) cap[rx_count] <= link_data;
      rx_count <= rx_count + 1;
      prev <= link_data[9:0];
      if (prev == 10'h3ff && link_data[9:0] == 10'h000) wrap_count <= wrap_count + 1;
    end
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Purpose: Self-checking bench for the converter alignment block
// Assumes: Serial port at ref_clk/10 or slower; receiver model drives the pin
// Notes:   Release counts are read one edge after the strobe is registered
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import adc_sync_pkg::*;
  logic              ref_clk = 1'b0;
  logic              link_clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              sync_req = 1'b0;
  logic              stall = 1'b0;
  logic              clear = 1'b1;
  logic              sclk = 1'b0;
  logic              cs_n = 1'b1;
  logic              mosi = 1'b0;
  logic [39:0]       sample_in = 40'h48d159e26b;
  logic              miso, oe_n, link_valid, link_ready, align_pin, oe_low;
  logic [3:0]        data_ready;
  logic [39:0]       link_data;
  logic [31:0][39:0] cap;
  logic [15:0]       rd;
  int                rx_count, wrap_count;
  int                err_total = 0;
  int                total_checks = 0;
  // Three edges take the pin edge, one raises the strobe, one more lets the bench see it
  localparam int     REL_BASE = int'(RELEASE_CYC) + 5;

  always #12.5 ref_clk = ~ref_clk;
  // Link edges fall on multiples of 80 ns and meet a falling ref_clk edge every 400 ns
  always #80 link_clk = ~link_clk;

  adc_sync_alignment dut (.ref_clk(ref_clk), .arst_n(arst_n), .link_clk(link_clk), .align_reset_in(align_pin),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_o(miso), .spi_miso_oe_n(oe_n),
    .sample_in(sample_in), .data_ready(data_ready), .link_data(link_data), .link_valid(link_valid),
    .link_ready(link_ready));
  link_receiver rx (.ref_clk(ref_clk), .link_clk(link_clk), .sync_req(sync_req), .stall(stall), .clear(clear),
    .link_valid(link_valid), .link_data(link_data), .link_ready(link_ready), .align_pin(align_pin), .cap(cap),
    .rx_count(rx_count), .wrap_count(wrap_count));

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic fail_wait();
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    stop_test();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Each sclk level lasts 5 or 10 ref_clk cycles, above the 4 the synchroniser needs
  task automatic spi(input logic rw, input logic [6:0] a, input logic [15:0] d);
    logic [23:0] f;
    f = {rw, a, d};
    @(posedge ref_clk);
    cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      cyc(5);
      mosi <= f[i];
      cyc(5);
      if (i == 15) oe_low = ~oe_n;
      if (i < 16) rd[i] = miso;
      sclk <= 1'b1;
      cyc(5);
      sclk <= 1'b0;
    end
    cyc(5);
    cs_n <= 1'b1;
    cyc(6);
  endtask

  task automatic wait_words(input int n);
    for (int i = 0; i < 9000 && rx_count < n; i++) cyc(1);
    if (rx_count < n) fail_wait();
  endtask

  // A short pulse train goes first; with extra delay 7 its last rise lands in the wait and must restart it
  task automatic align(input logic [15:0] c, input int exp);
    logic [3:0] any;
    logic       lo;
    int         n;
    any = 4'h0;
    lo = 1'b0;
    n = 0;
    spi(1'b0, ADDR_CONTROL_CONFIG, c);
    @(posedge ref_clk);
    clear <= 1'b1;
    repeat (3) begin
      sync_req <= 1'b1;
      cyc(6);
      sync_req <= 1'b0;
      cyc(6);
    end
    sync_req <= 1'b1;
    cyc(5);
    repeat (80) begin
      any |= data_ready;
      cyc(1);
    end
    check(40'(any), c[RM_BIT] ? 40'hf : 40'h0);
    sync_req <= 1'b0;
    clear <= 1'b0;
    while (n < 60 && (data_ready !== 4'hf || !lo)) begin
      cyc(1);
      n++;
      lo |= (data_ready === 4'h0);
    end
    if (n >= 60) fail_wait();
    if (exp > 0) check(40'(n), 40'(exp));
  endtask

  task automatic ramp_from(input int cnt);
    wait_words(cnt);
    for (int i = 0; i < cnt; i++) check(cap[i], {4{i[9:0]}});
  endtask

  task automatic t_regs();
    spi(1'b1, ADDR_CONTROL_CONFIG, 16'h0000);
    check(40'(rd), 40'(CONTROL_CONFIG_RST));
    check(40'(oe_low), 40'h1);
    // Running phase is one-hot 001; strobe and FIFO ready bits move and are masked
    spi(1'b1, ADDR_STATUS, 16'h0000);
    check(40'({rd[15:5], rd[2:0]}), 40'h1);
    spi(1'b0, ADDR_CONTROL_CONFIG, 16'h0cf5);
    spi(1'b0, 7'h05, 16'h1234);
    spi(1'b1, ADDR_CONTROL_CONFIG, 16'h0000);
    check(40'(rd), 40'h0cf5);
    spi(1'b1, 7'h05, 16'h0000);
    check(40'(rd), 40'h0);
    check(40'(oe_n), 40'h1);
    $display("regs done");
  endtask

  // Extra delay 0 or 7 and clock band off or on
  task automatic t_release();
    logic [15:0] c;
    for (int k = 0; k < 4; k++) begin
      c = {14'h0, TEST_RAMP};
      c[DLY_LSB +: 4] = k[0] ? 4'h7 : 4'h0;
      c[BAND_BIT] = k[1];
      align(c, REL_BASE + (k[0] ? 7 : 0) + int'(k[1]));
      ramp_from(16);
    end
    $display("release done");
  endtask

  task automatic t_flash();
    logic [15:0] c;
    int          z;
    for (int s = 0; s < 4; s++) begin
      c = {14'h0, TEST_FLASH};
      c[FLASH_LSB +: 2] = s[1:0];
      z = (s == 0) ? 10 : (s == 1) ? 11 : 15;
      align(c, REL_BASE);
      wait_words(z + 2);
      for (int i = 0; i <= z + 1; i++) check(cap[i], (i == 0 || i == z + 1) ? {4{SAMPLE_ONES}} : 40'h0);
    end
    $display("flash done");
  endtask

  task automatic t_rm();
    logic [15:0] c;
    c = {14'h0, TEST_RAMP};
    c[RM_BIT] = 1'b1;
    align(c, 0);
    $display("falling release done");
  endtask

  // Full FIFO must freeze the strobes and lose no sample
  task automatic t_stall();
    logic [3:0] d;
    align({14'h0, TEST_RAMP}, REL_BASE);
    wait_words(4);
    stall <= 1'b1;
    cyc(80);
    d = data_ready;
    repeat (20) begin
      cyc(1);
      check(40'(data_ready), 40'(d));
    end
    stall <= 1'b0;
    ramp_from(30);
    sync_req <= 1'b1;
    cyc(80);
    check(40'(link_valid), 40'h0);
    sync_req <= 1'b0;
    $display("stall done");
  endtask

  task automatic t_wrap();
    align({14'h0, TEST_RAMP}, REL_BASE);
    wait_words(1030);
    check(40'(wrap_count), 40'h1);
    $display("wrap done");
  endtask

  // Leaving the test mode without an alignment pulse
  task automatic t_normal();
    spi(1'b0, ADDR_CONTROL_CONFIG, {14'h0, TEST_NORMAL});
    clear <= 1'b1;
    cyc(80);
    clear <= 1'b0;
    wait_words(4);
    check(cap[3], sample_in);
    $display("normal done");
  endtask

  always @(posedge ref_clk) begin
    if (arst_n && data_ready !== 4'h0 && data_ready !== 4'hf) check(40'(data_ready), 40'hf);
  end

  initial begin
    cyc(6);
    arst_n <= 1'b1;
    cyc(4);
    t_regs();
    t_release();
    t_flash();
    t_rm();
    t_stall();
    t_wrap();
    t_normal();
    stop_test();
  end
endmodule
`default_nettype wire
